// ==== hw/gain_beep_pkg.sv ====
// Constants for the input gain and beep path control block.
// Assumes a 10 MHz system clock and APB register access.
package gain_beep_pkg;

  localparam int unsigned CLK_MHZ = 10;
  localparam int unsigned ZC_TIMEOUT_US = 100;
  localparam int unsigned ZC_TIMEOUT_CYC = ZC_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned ZC_CNT_W = 11;

  localparam int unsigned GAIN_W = 7;
  // Default gain code, 0 dB
  localparam logic [6:0] GAIN_DEFAULT = 7'h10;

  localparam logic [7:0] OFS_POWER = 8'h00;
  localparam logic [7:0] OFS_ROUTE = 8'h04;
  localparam logic [7:0] OFS_GAIN_CTRL = 8'h08;
  localparam logic [7:0] OFS_LEFT_GAIN = 8'h0C;
  localparam logic [7:0] OFS_RIGHT_GAIN = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // Power register fields
  localparam int unsigned PWR_MIC_L = 0;
  localparam int unsigned PWR_MIC_R = 1;
  localparam int unsigned PWR_STAGE_L = 2;
  localparam int unsigned PWR_STAGE_R = 3;
  localparam int unsigned PWR_ADC_R = 4;
  localparam int unsigned PWR_BEEP_MONO = 5;
  localparam int unsigned PWR_BEEP_STEREO = 6;
  localparam int unsigned PWR_W = 7;
  localparam logic [6:0] PWR_RESET = 7'h00;

  // Route register fields
  localparam int unsigned RT_MONO_HP = 0;
  localparam int unsigned RT_MONO_SP = 1;
  localparam int unsigned RT_STEREO_HP = 2;
  localparam int unsigned RT_STEREO_SP = 3;
  localparam int unsigned RT_W = 4;
  localparam logic [3:0] RT_RESET = 4'h0;

  // Gain control fields
  localparam int unsigned GC_ZERO_CROSS = 0;
  localparam int unsigned GC_AUTO_LEVEL = 1;
  localparam int unsigned GC_W = 2;
  localparam logic [1:0] GC_RESET = 2'h0;

  // Status fields: applied left [6:0], applied right [14:8], mode [17:16]
  localparam int unsigned ST_RIGHT_POS = 8;
  localparam int unsigned ST_MODE_POS = 16;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_MANUAL = 2'b01,
    MODE_AUTO = 2'b11
  } gain_mode_t;

endpackage : gain_beep_pkg

// ==== hw/zc_apply_timer.sv ====
// Holds one pending gain change until a zero crossing or a timeout.
// Assumes zeroCross is a synchronous one-cycle pulse per crossing.
`timescale 1ns/1ns
`default_nettype none
module zc_apply_timer
  import gain_beep_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic start, // new gain value written
  input wire logic zeroCross, // signal crossed zero
  output logic fire, // apply pending value now
  output logic waiting // a change is pending
);

  logic waiting_q;
  logic waiting_d;
  logic [ZC_CNT_W-1:0] count_q;
  logic [ZC_CNT_W-1:0] count_d;
  wire timedOut = (count_q == ZC_CNT_W'(ZC_TIMEOUT_CYC - 1));

  assign fire = waiting_q & ~start & (zeroCross | timedOut);
  assign waiting = waiting_q;
  assign waiting_d = start | (waiting_q & ~fire);
  assign count_d = (start | ~waiting_q) ? '0 : count_q + ZC_CNT_W'(1);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      waiting_q <= 1'b0;
      count_q <= '0;
    end
    else if (ce)
    begin
      waiting_q <= waiting_d;
      count_q <= count_d;
    end
  end

endmodule : zc_apply_timer
`default_nettype wire

// ==== hw/gain_beep_ctrl.sv ====
// Input gain stage control and beep path routing with an APB register file.
// Assumes the level control engine and zero detectors run on clk_sys.
//
// Contract
// - With zero-cross off, a gain write applies at once, any spacing.
// - A gain written while powered and level control is off is applied.
// - When level control turns off while powered, its last gain stays applied.
// - All four power bits low resets gain; power-up restarts from default.
// - A gain field reads back the last written value, not the applied one.
// - Mono beep routes follow only their route bits, not mono beep power.
// - Stereo beep routes follow only their route bits, not stereo power.
// - Beep routes need no running clock; they are static decodes.
// - Level control starts from the 0 dB default after power-up.
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
module gain_beep_ctrl
  import gain_beep_pkg::*;
(
  input wire logic clk_sys, // 10 MHz system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic ce, // clock enable, freezes state
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic alcStep, // level control gain update
  input wire logic [6:0] alcGainLeft, // level control left gain
  input wire logic [6:0] alcGainRight, // level control right gain
  input wire logic zeroCrossLeft, // left signal zero crossing
  input wire logic zeroCrossRight, // right signal zero crossing
  output logic [6:0] appliedGainLeft, // left gain in use
  output logic [6:0] appliedGainRight, // right gain in use
  output logic autoLevelRun, // level control active
  output logic leftMicPower, // left mic amp power
  output logic rightMicPower, // right mic amp power
  output logic leftGainStagePower, // left gain stage power
  output logic rightGainStagePower, // right gain stage power
  output logic rightAdcPower, // right ADC power
  output logic monoBeepPower, // mono beep input power
  output logic stereoBeepPower, // stereo beep input power
  output logic monoBeepToHeadphone, // mono beep to headphone amp
  output logic monoBeepToSpeaker, // mono beep to speaker amp
  output logic stereoBeepToHeadphone, // stereo beep to headphone amp
  output logic stereoBeepToSpeaker // stereo beep to speaker amp
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic [PWR_W-1:0] power_q;
  logic [RT_W-1:0] route_q;
  logic [GC_W-1:0] gainCtrl_q;
  logic [GAIN_W-1:0] gainField_q [2];
  logic [GAIN_W-1:0] applied_q [2];
  gain_mode_t mode_q;
  gain_mode_t mode_d;
  logic [31:0] prdata_q;
  logic captured_q;

  // Bus decode
  wire selPower = hit(paddr, OFS_POWER);
  wire selRoute = hit(paddr, OFS_ROUTE);
  wire selGainCtrl = hit(paddr, OFS_GAIN_CTRL);
  wire selLeft = hit(paddr, OFS_LEFT_GAIN);
  wire selRight = hit(paddr, OFS_RIGHT_GAIN);
  wire selStatus = hit(paddr, OFS_STATUS);
  wire mapped = selPower | selRoute | selGainCtrl | selLeft | selRight
    | selStatus;
  wire access = psel & penable & pready;
  wire wrOk = access & pwrite & mapped;
  wire [1:0] wrGain = {wrOk & selRight, wrOk & selLeft};

  assign pready = penable & ce & captured_q;
  assign pslverr = pready & ~mapped;
  assign prdata = prdata_q;

  wire [31:0] statusWord = {14'h0000, mode_q, 1'b0, applied_q[1], 1'b0,
    applied_q[0]};
  wire [31:0] readMux =
    selPower ? {25'h0000000, power_q} :
    selRoute ? {28'h0000000, route_q} :
    selGainCtrl ? {30'h00000000, gainCtrl_q} :
    selLeft ? {25'h0000000, gainField_q[0]} :
    selRight ? {25'h0000000, gainField_q[1]} :
    selStatus ? statusWord : 32'h00000000;

  // Capture read data in setup and while waiting
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      prdata_q <= 32'h00000000;
      captured_q <= 1'b0;
    end
    else if (ce)
    begin
      prdata_q <= readMux;
      captured_q <= psel & ~access;
    end
  end

  // Control registers
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      power_q <= PWR_RESET;
      route_q <= RT_RESET;
      gainCtrl_q <= GC_RESET;
    end
    else if (ce)
    begin
      if (wrOk & selPower)
        power_q <= pwdata[PWR_W-1:0];
      if (wrOk & selRoute)
        route_q <= pwdata[RT_W-1:0];
      if (wrOk & selGainCtrl)
        gainCtrl_q <= pwdata[GC_W-1:0];
    end
  end

  // Gain state
  wire powerAny = power_q[PWR_MIC_L] | power_q[PWR_MIC_R]
    | power_q[PWR_STAGE_L] | power_q[PWR_STAGE_R];
  wire autoLevelEn = gainCtrl_q[GC_AUTO_LEVEL];
  wire zcOption = gainCtrl_q[GC_ZERO_CROSS];
  wire manualMode = (mode_q == MODE_MANUAL) & (mode_d == MODE_MANUAL);
  wire [1:0] zeroCross = {zeroCrossRight, zeroCrossLeft};
  wire [GAIN_W-1:0] alcGain [2];
  assign alcGain[0] = alcGainLeft;
  assign alcGain[1] = alcGainRight;

  always_comb
  begin
    if (!powerAny)
      mode_d = MODE_OFF;
    else if (autoLevelEn)
      mode_d = MODE_AUTO;
    else
      mode_d = MODE_MANUAL;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      mode_q <= MODE_OFF;
    else if (ce)
      mode_q <= mode_d;
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_chan
      logic fire;
      logic [GAIN_W-1:0] applied_d;
      wire zcStart = wrGain[ch] & zcOption & manualMode;
      wire directApply = wrGain[ch] & ~zcOption & manualMode;

      zc_apply_timer u_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .start(zcStart),
        .zeroCross(zeroCross[ch]),
        .fire(fire),
        .waiting()
      );

      always_comb
      begin
        applied_d = applied_q[ch];
        if (mode_d == MODE_OFF)
          applied_d = GAIN_DEFAULT;
        else if (mode_q == MODE_OFF)
          applied_d = GAIN_DEFAULT;
        // level control owns gain, kept if it stops while powered
        else if (mode_d == MODE_AUTO)
        begin
          if (alcStep)
            applied_d = alcGain[ch];
        end
        // host preset applied in manual mode
        else if (directApply)
          applied_d = pwdata[GAIN_W-1:0];
        else if (fire & manualMode)
          applied_d = gainField_q[ch];
      end

      always_ff @(posedge clk_sys)
      begin
        if (!rst_n)
        begin
          applied_q[ch] <= GAIN_DEFAULT;
          gainField_q[ch] <= GAIN_DEFAULT;
        end
        else if (ce)
        begin
          applied_q[ch] <= applied_d;
          if (wrGain[ch])
            gainField_q[ch] <= pwdata[GAIN_W-1:0];
        end
      end
    end
  endgenerate

  assign appliedGainLeft = applied_q[0];
  assign appliedGainRight = applied_q[1];
  assign autoLevelRun = (mode_q == MODE_AUTO);

  assign leftMicPower = power_q[PWR_MIC_L];
  // right channel powers under host control
  assign rightMicPower = power_q[PWR_MIC_R];
  assign leftGainStagePower = power_q[PWR_STAGE_L];
  assign rightGainStagePower = power_q[PWR_STAGE_R];
  assign rightAdcPower = power_q[PWR_ADC_R];
  assign monoBeepPower = power_q[PWR_BEEP_MONO];
  assign stereoBeepPower = power_q[PWR_BEEP_STEREO];

  // static route decode, no clock in path
  // mono routes ignore mono beep power
  assign monoBeepToHeadphone = route_q[RT_MONO_HP];
  assign monoBeepToSpeaker = route_q[RT_MONO_SP];
  // stereo routes ignore stereo beep power
  assign stereoBeepToHeadphone = route_q[RT_STEREO_HP];
  assign stereoBeepToSpeaker = route_q[RT_STEREO_SP];

endmodule : gain_beep_ctrl
`default_nettype wire

// ==== testbench/gain_beep_monitor.sv ====
// Port checker for the gain and beep control block.
// Bound from the bench top file; sees only top-level ports.
`timescale 1ns/1ns
`default_nettype none
module gain_beep_monitor
  import gain_beep_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic rst_n, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic psel, // bus select
  input wire logic penable, // bus enable
  input wire logic pwrite, // bus direction
  input wire logic [7:0] paddr, // byte address
  input wire logic [31:0] pwdata, // write data
  input wire logic pready, // bus answer
  input wire logic autoLevelRun, // level control mode
  input wire logic [6:0] appliedGainLeft, // gain in use
  input wire logic leftMicPower, // left mic power
  input wire logic rightMicPower, // right mic power
  input wire logic leftGainStagePower, // left stage power
  input wire logic rightGainStagePower, // right stage power
  input wire logic monoBeepPower, // mono beep power
  input wire logic stereoBeepPower, // stereo beep power
  input wire logic monoBeepToHeadphone, // mono route
  input wire logic monoBeepToSpeaker, // mono route
  input wire logic stereoBeepToHeadphone, // stereo route
  input wire logic stereoBeepToSpeaker // stereo route
);
  logic zcOn_q;
  logic [6:0] lastL_q;
  logic [10:0] zcWait_q;
  wire acc = psel && penable && pready;
  wire wrL = acc && pwrite && paddr == OFS_LEFT_GAIN;
  wire pw = leftMicPower | rightMicPower | leftGainStagePower
    | rightGainStagePower;
  wire man = wrL && pw && !autoLevelRun;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Shadow of the zero-cross option and last left write
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      zcOn_q <= 1'h0;
    else if (acc && pwrite && paddr == OFS_GAIN_CTRL)
      zcOn_q <= pwdata[GC_ZERO_CROSS];
    if (wrL)
      lastL_q <= pwdata[6:0];
  end
  // Enabled cycles since a deferred left write, held at its ceiling
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      zcWait_q <= 11'h000;
    else if (man && zcOn_q)
      zcWait_q <= 11'h001;
    else if (appliedGainLeft == lastL_q)
      zcWait_q <= 11'h000;
    else if (ce && zcWait_q != 11'h000 && zcWait_q != 11'h3EC)
      zcWait_q <= zcWait_q + 11'h001;
  end
  chk_gain_direct: assert property (
    man && !zcOn_q |=> appliedGainLeft == lastL_q) else $error("direct gain");
  chk_gain_deferred: assert property (
    man && zcOn_q |=> $stable(appliedGainLeft)) else $error("gain too early");
  chk_gain_timeout: assert property (
    zcWait_q < 11'h3EC) else $error("gain never applied");
  chk_auto_hold: assert property (
    $fell(autoLevelRun) && pw |-> $stable(appliedGainLeft))
    else $error("auto gain lost");
  chk_power_reset: assert property (
    !pw |=> appliedGainLeft == GAIN_DEFAULT) else $error("gain not reset");
  chk_power_restart: assert property (
    $rose(pw) |-> appliedGainLeft == GAIN_DEFAULT) else $error("bad restart");
  chk_mono_routes: assert property (
    $fell(monoBeepPower) |-> $stable({monoBeepToHeadphone, monoBeepToSpeaker}))
    else $error("mono route broken");
  chk_stereo_route: assert property (
    $fell(stereoBeepPower)
    |-> $stable({stereoBeepToHeadphone, stereoBeepToSpeaker}))
    else $error("stereo route broken");
  chk_route_static: assert property (
    !(acc && pwrite) |=> $stable({monoBeepToHeadphone, stereoBeepToSpeaker}))
    else $error("route moved");
endmodule : gain_beep_monitor
`default_nettype wire

// ==== testbench/alc_source_model.sv ====
// Level control engine and zero detectors feeding the block.
// Commands come from the bench as one-cycle requests.
`timescale 1ns/1ns
`default_nettype none
module alc_source_model
(
  input wire logic clk_sys, // system clock
  input wire logic stepReq, // level step command
  input wire logic crossReq, // zero crossing command
  input wire logic [13:0] stepGain, // right, left offer
  output logic alcStep = 1'h0, // step pulse
  output logic zeroCrossLeft = 1'h0, // left crossing pulse
  output logic zeroCrossRight = 1'h0, // right crossing pulse
  output logic [6:0] alcGainLeft = 7'h00, // left gain offer
  output logic [6:0] alcGainRight = 7'h00 // right gain offer
);
  // gains valid only with the step pulse
  always_ff @(posedge clk_sys)
  begin
    alcStep <= stepReq;
    zeroCrossLeft <= crossReq;
    zeroCrossRight <= crossReq;
    {alcGainRight, alcGainLeft} <= stepReq ? stepGain
      : ~{alcGainRight, alcGainLeft};
  end
endmodule : alc_source_model
`default_nettype wire

// ==== testbench/test_input_gain_beep_path_control.sv ====
// Self-checking bench for the gain and beep control block.
// Drives APB as master; reads are checked from a queue.
`timescale 1ns/1ns
`default_nettype none
module test_input_gain_beep_path_control;
  import gain_beep_pkg::*;
  logic clk_sys = 1'h0, rst_n = 1'h0, ce = 1'h1, psel = 1'h0;
  logic penable = 1'h0, pwrite = 1'h0, pready, pslverr;
  logic stepReq = 1'h0, crossReq = 1'h0, alcStep, zcL, zcR;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [13:0] stepGain = 14'h0, g;
  logic [6:0] gL, gR, a, b, c;
  logic [32:0] expQ[$];
  wire [25:0] pins;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  gain_beep_ctrl dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alcStep(alcStep), .alcGainLeft(gL), .alcGainRight(gR),
    .zeroCrossLeft(zcL), .zeroCrossRight(zcR),
    .appliedGainLeft(pins[25:19]), .autoLevelRun(pins[18]),
    .appliedGainRight(pins[17:11]), .stereoBeepToSpeaker(pins[10]),
    .stereoBeepToHeadphone(pins[9]), .monoBeepToSpeaker(pins[8]),
    .monoBeepToHeadphone(pins[7]), .stereoBeepPower(pins[6]),
    .monoBeepPower(pins[5]), .rightAdcPower(pins[4]),
    .rightGainStagePower(pins[3]), .leftGainStagePower(pins[2]),
    .rightMicPower(pins[1]), .leftMicPower(pins[0]));
  alc_source_model src_u (.clk_sys(clk_sys), .stepReq(stepReq),
    .crossReq(crossReq), .stepGain(stepGain), .alcStep(alcStep),
    .zeroCrossLeft(zcL), .zeroCrossRight(zcR), .alcGainLeft(gL),
    .alcGainRight(gR));
  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic close_out;
    $display("compared %0d mismatched %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic cmp_read(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: read %h expected %h", $time, got, exp);
    end
  endtask : cmp_read
  // Gains, mode, routes and power bits as seen on the pins
  task automatic cmp_pins(input logic [25:0] exp);
    samples_checked++;
    if (pins !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: pins %h expected %h", $time, pins, exp);
    end
  endtask : cmp_pins
  task automatic apb(input logic wr, input logic [7:0] ad,
    input logic [31:0] d, input logic [32:0] e);
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    if (!wr)
      expQ.push_back(e);
    @(posedge clk_sys);
    penable <= 1'h1;
    do
      @(posedge clk_sys);
    while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'h1, ad, d, 33'h0);
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    apb(1'h0, ad, 32'h0, {1'h0, e});
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : idle
  function automatic logic [31:0] st(input gain_mode_t m,
    input logic [6:0] r, input logic [6:0] l);
    return {14'h0, m, 1'h0, r, 1'h0, l};
  endfunction : st
  // Read results matched against the oldest note
  always @(posedge clk_sys)
  begin
    cyc++;
    if (psel && penable && pready === 1'h1 && !pwrite)
      cmp_read({pslverr, prdata}, expQ.size() ? expQ.pop_front() : 33'h0);
    if (cyc == 10000)
    begin
      error_cnt++;
      close_out;
    end
  end
  initial
  begin
    void'($urandom(32'hdba3));
    a = 7'($urandom);
    b = 7'($urandom);
    g = 14'($urandom);
    c = ~a;
    idle(6);
    rst_n <= 1'h1;
    rd(OFS_STATUS, st(MODE_OFF, 7'h10, 7'h10));
    rd(OFS_LEFT_GAIN, 32'h10);
    apb(1'h0, 8'h18, 32'h0, {1'h1, 32'h0});
    wr(OFS_POWER, 32'h1F);
    wr(OFS_LEFT_GAIN, {25'h0, a});
    wr(OFS_RIGHT_GAIN, {25'h0, b});
    rd(OFS_STATUS, st(MODE_MANUAL, b, a));
    cmp_pins({a, 1'h0, b, 4'h0, 7'h1F});
    $display("test manual done");
    wr(OFS_GAIN_CTRL, 32'h1);
    wr(OFS_LEFT_GAIN, {25'h0, c});
    rd(OFS_STATUS, st(MODE_MANUAL, b, a));
    crossReq <= 1'h1;
    idle(1);
    crossReq <= 1'h0;
    idle(3);
    rd(OFS_STATUS, st(MODE_MANUAL, b, c));
    idle(1001);
    wr(OFS_RIGHT_GAIN, {25'h0, ~b});
    // Clock enable low stretches the timeout by 20 cycles
    ce <= 1'h0;
    idle(20);
    ce <= 1'h1;
    idle(480);
    rd(OFS_STATUS, st(MODE_MANUAL, b, c));
    idle(500);
    rd(OFS_STATUS, st(MODE_MANUAL, b, c));
    idle(20);
    rd(OFS_STATUS, st(MODE_MANUAL, ~b, c));
    $display("test zero cross done");
    wr(OFS_GAIN_CTRL, 32'h2);
    rd(OFS_STATUS, st(MODE_AUTO, ~b, c));
    stepGain <= g;
    stepReq <= 1'h1;
    idle(1);
    stepReq <= 1'h0;
    idle(3);
    rd(OFS_STATUS, st(MODE_AUTO, g[13:7], g[6:0]));
    cmp_pins({g[6:0], 1'h1, g[13:7], 4'h0, 7'h1F});
    wr(OFS_GAIN_CTRL, 32'h0);
    rd(OFS_STATUS, st(MODE_MANUAL, g[13:7], g[6:0]));
    rd(OFS_LEFT_GAIN, {25'h0, c});
    $display("test auto done");
    wr(OFS_POWER, 32'h0);
    rd(OFS_STATUS, st(MODE_OFF, 7'h10, 7'h10));
    wr(OFS_POWER, 32'h1);
    rd(OFS_STATUS, st(MODE_MANUAL, 7'h10, 7'h10));
    $display("test power done");
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_ROUTE, 32'h1 << i);
      rd(OFS_ROUTE, 32'h1 << i);
    end
    wr(OFS_ROUTE, 32'hF);
    wr(OFS_POWER, 32'h61);
    wr(OFS_POWER, 32'h1);
    rd(OFS_ROUTE, 32'hF);
    cmp_pins({7'h10, 1'h0, 7'h10, 4'hF, 7'h01});
    $display("test beep done");
    idle(2);
    close_out;
  end
endmodule : test_input_gain_beep_path_control
bind gain_beep_ctrl gain_beep_monitor chk_u (.clk_sys(clk_sys),
  .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .autoLevelRun(autoLevelRun), .appliedGainLeft(appliedGainLeft),
  .leftMicPower(leftMicPower), .rightMicPower(rightMicPower),
  .leftGainStagePower(leftGainStagePower),
  .rightGainStagePower(rightGainStagePower),
  .monoBeepPower(monoBeepPower), .stereoBeepPower(stereoBeepPower),
  .monoBeepToHeadphone(monoBeepToHeadphone),
  .monoBeepToSpeaker(monoBeepToSpeaker),
  .stereoBeepToHeadphone(stereoBeepToHeadphone),
  .stereoBeepToSpeaker(stereoBeepToSpeaker));
`default_nettype wire
